// *** hdl/elm_pkg.sv ***
/*
 * Shared constants and types for the engine mapping and loop branch logic:
 * command codes, instruction field positions, row layout, register offsets.
 * Assumes a single core clock and a master-clock tick from the same domain.
 */
package elm_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int          ENGINES      = 3;
	localparam int          DRIVERS      = 9;
	localparam int          OUTS         = 10;     // Nine drivers plus the general output pin
	localparam int          SRAM_ROWS    = 96;
	localparam int          ADDR_W       = 7;
	localparam int          WORD_W       = 16;
	localparam int          LOOP_W       = 6;
	localparam int          BUS_AW       = 8;
	localparam int          BUS_DW       = 32;

	// ------------------------------------------------------------
	// Row layout and select codes
	// ------------------------------------------------------------
	localparam int          ROW_GPO_BIT  = 9;      // Bits 8..0 enable drivers 9..1
	localparam logic [4:0]  SEL_NONE     = 5'h00;
	localparam logic [4:0]  SEL_LAST_LED = 5'h09;
	localparam logic [4:0]  SEL_GPO      = 5'h10;

	// ------------------------------------------------------------
	// Instruction argument fields
	// ------------------------------------------------------------
	localparam int          ARG_ADDR_LSB = 0;      // Address / step number [6:0]
	localparam int          ARG_SEL_LSB  = 0;      // Output select [4:0]
	localparam int          ARG_CNT_LSB  = 7;      // Numeric loop count [12:7]
	localparam int          ARG_VAR_LSB  = 7;      // Variable selector [8:7]

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam logic [4:0]  BRANCH_TICKS = 5'h10;  // Master clock cycles per branch

	// ------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_VAR_D    = 8'h04;
	localparam logic [7:0]  REG_TABLE0   = 8'h08;  // Plus 4 per engine
	localparam logic [7:0]  REG_MAP0     = 8'h14;  // Plus 4 per engine
	localparam int          CTRL_DSRC    = 0;      // 1: selector 3 reads the test converter
	localparam int          CTRL_GPO     = 1;      // Serial-bus level of the output pin
	localparam logic [7:0]  RST_VAR_D    = 8'h00;
	localparam int          TBL_PTR_LSB  = 0;
	localparam int          TBL_BEG_LSB  = 8;
	localparam int          TBL_END_LSB  = 16;

	// ------------------------------------------------------------
	// Commands (decoded instruction kinds)
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ELM_OP_TB_BEGIN     = 4'h0,
		ELM_OP_TB_BEGIN_ACT = 4'h1,
		ELM_OP_TB_FINISH    = 4'h2,
		ELM_OP_SEL          = 4'h3,
		ELM_OP_CLR          = 4'h4,
		ELM_OP_ACT_NEXT     = 4'h5,
		ELM_OP_ACT_PREV     = 4'h6,
		ELM_OP_PTR_NEXT     = 4'h7,
		ELM_OP_PTR_PREV     = 4'h8,
		ELM_OP_PTR_AT       = 4'h9,
		ELM_OP_ACT_AT       = 4'ha,
		ELM_OP_BRANCH_NUM   = 4'hb,
		ELM_OP_BRANCH_VAR   = 4'hc
	} elm_op_t;

	typedef enum logic [2:0] {
		ELM_ST_IDLE = 3'b001,
		ELM_ST_ROW  = 3'b010,
		ELM_ST_BR   = 3'b100
	} elm_state_t;

endpackage

// *** hdl/elm_core.sv ***
/*
 * Engine-to-output mapping and loop branch execution for three engines.
 * Assumes the sequencer issues decoded commands, the program SRAM answers a
 * read in the same cycle as its strobe, and mclk_tick pulses once per master clock period,
 * all on core_clk.
 */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps

module elm_core (
	input  wire logic            core_clk,
	input  wire logic            rst,
	// Command issue
	input  wire logic            cmd_valid,
	output logic                 cmd_ready,
	input  wire logic [1:0]      cmd_engine,
	input  wire logic [3:0]      cmd_op,
	input  wire logic [15:0]     cmd_arg,
	input  wire logic [6:0]      cmd_pc,
	output logic                 cmd_done,
	output logic                 pc_load,
	output logic [6:0]           pc_value,
	input  wire logic            mclk_tick,
	// Engine variables
	input  wire logic [2:0][7:0] var_a,
	input  wire logic [2:0][7:0] var_b,
	input  wire logic [7:0]      var_c,
	input  wire logic [7:0]      adc_value,
	// Program SRAM read port
	output logic                 sram_rd,
	output logic [6:0]           sram_addr,
	input  wire logic [15:0]     sram_rdata,
	// Engine duty writes and pin level
	input  wire logic [2:0]      eng_pwm_set,
	input  wire logic [2:0][7:0] eng_pwm_val,
	input  wire logic [2:0]      eng_gpo_level,
	// Driver side
	output logic [8:0][1:0]      led_owner,
	output logic [8:0]           led_pwm_wr,
	output logic [8:0][7:0]      led_pwm_data,
	output logic                 general_output_pin,
	// Register port
	input  wire logic [7:0]      reg_addr,
	input  wire logic [31:0]     reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic [31:0]          reg_rdata
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		elm_pkg::elm_state_t   state;
		logic [1:0]            eng;
		elm_pkg::elm_op_t      op;
		logic                  take;
		logic [4:0]            ticks;
		logic [2:0][6:0]       tbl_begin;
		logic [2:0][6:0]       tbl_finish;
		logic [2:0][6:0]       ptr;
		logic [2:0][9:0]       mask;
		logic [2:0][95:0]      lp_act;
		logic [2:0][95:0][5:0] lp_cnt;
		logic                  ctrl_dsrc;
		logic                  ctrl_gpo;
		logic [7:0]            var_d;
		logic [31:0]           rdata;
		logic                  sram_rd;
		logic [6:0]            sram_addr;
		logic                  done;
		logic                  pc_load;
		logic [6:0]            pc_value;
		logic [8:0][1:0]       owner;
		logic                  gpo_mapped;
		logic [8:0]            pwm_wr;
		logic [8:0][7:0]       pwm_data;
		logic                  gpo_out;
	} elm_regs_t;

	elm_regs_t                                  s;
	elm_regs_t                                  next_s;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Step a row index forward or back inside the table, wrapping at the ends
	function automatic logic [6:0] row_step(input logic [6:0] p, input logic [6:0] b,
		input logic [6:0] f, input logic fwd);
		logic [6:0] r;
		r = p;
		if (fwd) begin
			r = (p == f) ? b : p + 7'h01;
		end else begin
			r = (p == b) ? f : p - 7'h01;
		end
		return r;
	endfunction

	// Variable source for the variable branch
	function automatic logic [5:0] var_pick(input logic [1:0] sel, input logic [1:0] e,
		input logic dsrc, input logic [7:0] d);
		logic [7:0] v;
		v = 8'h00;
		unique case (sel)
			2'h0: v = var_a[e];
			2'h1: v = var_b[e];
			2'h2: v = var_c;
			2'h3: v = dsrc ? adc_value : d;
		endcase
		return v[5:0];
	endfunction

	// Output mask for a single select code; unlisted codes select nothing
	function automatic logic [9:0] sel_mask(input logic [4:0] code);
		logic [9:0] m;
		m = 10'h000;
		if (code == elm_pkg::SEL_GPO) begin
			m[elm_pkg::ROW_GPO_BIT] = 1'b1;
		end else if (code != elm_pkg::SEL_NONE && code <= elm_pkg::SEL_LAST_LED) begin
			m[code[3:0] - 4'h1] = 1'b1;
		end
		return m;
	endfunction

	// Register read mux; unmapped offsets read zero
	function automatic logic [31:0] reg_read(input logic [7:0] a, input elm_regs_t r);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == elm_pkg::REG_CTRL) begin
			v[elm_pkg::CTRL_DSRC] = r.ctrl_dsrc;
			v[elm_pkg::CTRL_GPO]  = r.ctrl_gpo;
		end else if (a == elm_pkg::REG_VAR_D) begin
			v[7:0] = r.var_d;
		end
		for (int e = 0; e < elm_pkg::ENGINES; e++) begin
			if (a == elm_pkg::REG_TABLE0 + 8'(4 * e)) begin
				v[elm_pkg::TBL_PTR_LSB +: 7] = r.ptr[e];
				v[elm_pkg::TBL_BEG_LSB +: 7] = r.tbl_begin[e];
				v[elm_pkg::TBL_END_LSB +: 7] = r.tbl_finish[e];
			end
			if (a == elm_pkg::REG_MAP0 + 8'(4 * e)) begin
				v[9:0] = r.mask[e];
			end
		end
		return v;
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [1:0] e;
		logic [6:0] a;
		logic [6:0] np;
		logic [5:0] cnt;
		logic [6:0] bpc;
		e   = cmd_engine;
		a   = cmd_arg[elm_pkg::ARG_ADDR_LSB +: 7];
		np  = 7'h00;
		cnt = 6'h00;
		bpc = cmd_pc;
		next_s = s;
		next_s.done    = 1'b0;
		next_s.pc_load = 1'b0;
		next_s.sram_rd = 1'b0;
		next_s.pwm_wr  = '0;
		next_s.rdata   = 32'h0000_0000;

		// Register port: write takes effect next edge, read data stands one cycle
		if (reg_wr) begin
			if (reg_addr == elm_pkg::REG_CTRL) begin
				next_s.ctrl_dsrc = reg_wdata[elm_pkg::CTRL_DSRC];
				next_s.ctrl_gpo  = reg_wdata[elm_pkg::CTRL_GPO];
			end else if (reg_addr == elm_pkg::REG_VAR_D) begin
				next_s.var_d = reg_wdata[7:0];
			end
		end
		if (reg_rd) begin
			next_s.rdata = reg_read(reg_addr, s);
		end

		// Ownership: lowest engine wins a driver claimed twice
		for (int l = 0; l < elm_pkg::DRIVERS; l++) begin
			next_s.owner[l] = 2'h0;
			for (int k = elm_pkg::ENGINES - 1; k >= 0; k--) begin
				if (s.mask[k][l]) begin
					next_s.owner[l] = 2'(k + 1);
				end
			end
		end

		// Duty values reach a driver only on an engine duty write
		for (int l = 0; l < elm_pkg::DRIVERS; l++) begin
			if (s.owner[l] != 2'h0 && eng_pwm_set[s.owner[l] - 2'h1]) begin
				next_s.pwm_wr[l]   = 1'b1;
				next_s.pwm_data[l] = eng_pwm_val[s.owner[l] - 2'h1];
			end
		end

		// Pin: mapped engine drives it, otherwise the serial-bus level
		next_s.gpo_mapped = 1'b0;
		next_s.gpo_out    = s.ctrl_gpo;
		for (int k = elm_pkg::ENGINES - 1; k >= 0; k--) begin
			if (s.mask[k][elm_pkg::ROW_GPO_BIT]) begin
				next_s.gpo_mapped = 1'b1;
				next_s.gpo_out    = eng_gpo_level[k];
			end
		end

		// Command sequencing
		unique case (s.state)
			elm_pkg::ELM_ST_IDLE: begin
				if (cmd_valid) begin
					next_s.eng = e;
					next_s.op  = elm_pkg::elm_op_t'(cmd_op);
					if (e == 2'h3) begin
						next_s.done = 1'b1;  // No such engine: finish with no effect
					end else begin
						unique case (elm_pkg::elm_op_t'(cmd_op))
							elm_pkg::ELM_OP_TB_BEGIN: begin
								next_s.tbl_begin[e] = a;
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_TB_FINISH: begin
								next_s.tbl_finish[e] = a;
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_TB_BEGIN_ACT: begin
								next_s.tbl_begin[e] = a;
								np = a;
							end
							elm_pkg::ELM_OP_SEL: begin
								next_s.mask[e] = sel_mask(cmd_arg[elm_pkg::ARG_SEL_LSB +: 5]);
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_CLR: begin
								next_s.mask[e] = 10'h000;
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_ACT_NEXT: begin
								np = row_step(s.ptr[e], s.tbl_begin[e], s.tbl_finish[e], 1'b1);
							end
							elm_pkg::ELM_OP_ACT_PREV: begin
								np = row_step(s.ptr[e], s.tbl_begin[e], s.tbl_finish[e], 1'b0);
							end
							elm_pkg::ELM_OP_PTR_NEXT: begin
								next_s.ptr[e] = row_step(s.ptr[e], s.tbl_begin[e], s.tbl_finish[e], 1'b1);
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_PTR_PREV: begin
								next_s.ptr[e] = row_step(s.ptr[e], s.tbl_begin[e], s.tbl_finish[e], 1'b0);
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_PTR_AT: begin
								next_s.ptr[e] = a;
								next_s.done = 1'b1;
							end
							elm_pkg::ELM_OP_ACT_AT: begin
								np = a;
							end
							elm_pkg::ELM_OP_BRANCH_NUM, elm_pkg::ELM_OP_BRANCH_VAR: begin
								if (elm_pkg::elm_op_t'(cmd_op) == elm_pkg::ELM_OP_BRANCH_VAR) begin
									cnt = var_pick(cmd_arg[elm_pkg::ARG_VAR_LSB +: 2], e, s.ctrl_dsrc,
										s.var_d);
								end else begin
									cnt = cmd_arg[elm_pkg::ARG_CNT_LSB +: elm_pkg::LOOP_W];
								end
								next_s.pc_value = a;
								next_s.take     = 1'b1;
								if (cnt == 6'h00 || bpc >= 7'(elm_pkg::SRAM_ROWS)) begin
									next_s.take = 1'b1;
								end else if (!s.lp_act[e][bpc]) begin
									next_s.lp_act[e][bpc] = 1'b1;
									next_s.lp_cnt[e][bpc] = cnt - 6'h01;
								end else if (s.lp_cnt[e][bpc] == 6'h00) begin
									next_s.lp_act[e][bpc] = 1'b0;
									next_s.take = 1'b0;
								end else begin
									next_s.lp_cnt[e][bpc] = s.lp_cnt[e][bpc] - 6'h01;
								end
								next_s.ticks = 5'h00;
								next_s.state = elm_pkg::ELM_ST_BR;
							end
							default: begin
								next_s.done = 1'b1;  // Unknown command: finish with no effect
							end
						endcase
						// Activating commands fetch the row from program SRAM
						if (elm_pkg::elm_op_t'(cmd_op) inside {elm_pkg::ELM_OP_TB_BEGIN_ACT,
							elm_pkg::ELM_OP_ACT_NEXT, elm_pkg::ELM_OP_ACT_PREV, elm_pkg::ELM_OP_ACT_AT}) begin
							next_s.ptr[e]    = np;
							next_s.sram_rd   = 1'b1;
							next_s.sram_addr = np;
							next_s.state     = elm_pkg::ELM_ST_ROW;
						end
					end
				end
			end
			elm_pkg::ELM_ST_ROW: begin
				// Row data stands this cycle; connect exactly its enabled outputs
				next_s.mask[s.eng] = sram_rdata[elm_pkg::OUTS - 1:0];
				next_s.done  = 1'b1;
				next_s.state = elm_pkg::ELM_ST_IDLE;
			end
			elm_pkg::ELM_ST_BR: begin
				if (mclk_tick) begin
					next_s.ticks = s.ticks + 5'h01;
					if (s.ticks == elm_pkg::BRANCH_TICKS - 5'h01) begin
						next_s.done    = 1'b1;
						next_s.pc_load = s.take;
						next_s.state   = elm_pkg::ELM_ST_IDLE;
					end
				end
			end
			default: begin
				next_s.state = elm_pkg::ELM_ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s       <= '0;
			s.state <= elm_pkg::ELM_ST_IDLE;
			s.op    <= elm_pkg::ELM_OP_TB_BEGIN;
			s.var_d <= elm_pkg::RST_VAR_D;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cmd_ready          = (s.state == elm_pkg::ELM_ST_IDLE);
	assign cmd_done           = s.done;
	assign pc_load            = s.pc_load;
	assign pc_value           = s.pc_value;
	assign sram_rd            = s.sram_rd;
	assign sram_addr          = s.sram_addr;
	assign led_owner          = s.owner;
	assign led_pwm_wr         = s.pwm_wr;
	assign led_pwm_data       = s.pwm_data;
	assign general_output_pin = s.gpo_out;
	assign reg_rdata          = s.rdata;

endmodule

// *** sim/elm_core_props.sv ***
/*
 * Checker for the engine mapping and loop branch logic, bound to elm_core.
 * Assumes one clock domain and a registered command, SRAM and register port.
 */
`timescale 1ns/1ps

module elm_core_props (
	input wire logic             core_clk,
	input wire logic             rst,
	input wire logic             cmd_valid,
	input wire logic             cmd_ready,
	input wire logic [1:0]       cmd_engine,
	input wire logic [3:0]       cmd_op,
	input wire logic [15:0]      cmd_arg,
	input wire logic             cmd_done,
	input wire logic             pc_load,
	input wire logic             mclk_tick,
	input wire logic             sram_rd,
	input wire logic [6:0]       sram_addr,
	input wire logic [2:0]       eng_pwm_set,
	input wire logic [2:0][7:0]  eng_pwm_val,
	input wire logic [8:0][1:0]  led_owner,
	input wire logic [8:0]       led_pwm_wr,
	input wire logic [8:0][7:0]  led_pwm_data,
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	logic        take;
	logic        is_br;
	logic        is_act;
	logic        br_busy;
	logic [4:0]  br_cnt;
	logic [15:0] arg_q;
	logic [7:0]  val_q;

	// Accepted command classes
	assign take   = cmd_valid && cmd_ready && (cmd_engine != 2'h3);
	assign is_br  = cmd_op inside {elm_pkg::ELM_OP_BRANCH_NUM, elm_pkg::ELM_OP_BRANCH_VAR};
	assign is_act = cmd_op inside {elm_pkg::ELM_OP_TB_BEGIN_ACT, elm_pkg::ELM_OP_ACT_NEXT,
		elm_pkg::ELM_OP_ACT_PREV, elm_pkg::ELM_OP_ACT_AT};

	// Counts master ticks while a branch runs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			br_busy <= 1'b0;
			br_cnt  <= 5'h00;
			arg_q   <= 16'h0000;
			val_q   <= 8'h00;
		end else begin
			arg_q <= cmd_arg;
			val_q <= eng_pwm_val[0];
			if (take && is_br) begin
				br_busy <= 1'b1;
				br_cnt  <= 5'h00;
			end else if (br_busy && cmd_done) begin
				br_busy <= 1'b0;
			end else if (br_busy && mclk_tick) begin
				br_cnt <= br_cnt + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_act_row_read: assert property (take && is_act |=> sram_rd && !cmd_ready ##1 cmd_done)
		else $error("row fetch late");
	a_act_at_addr: assert property (take && cmd_op == elm_pkg::ELM_OP_ACT_AT |=> sram_addr == arg_q[6:0])
		else $error("wrong row read");
	a_quick_done: assert property (take && !is_br && !is_act |=> cmd_done && !sram_rd)
		else $error("quick command late");
	a_branch_early: assert property (br_busy && br_cnt < 5'h10 |-> !cmd_done)
		else $error("branch ended early");
	a_branch_len: assert property (br_busy && cmd_done |-> br_cnt == 5'h10)
		else $error("branch length wrong");
	a_pc_with_br: assert property (pc_load |-> cmd_done && br_busy)
		else $error("stray pc load");
	a_duty_only: assert property (led_pwm_wr != 9'h000 |-> $past(eng_pwm_set) != 3'h0)
		else $error("stray duty write");
	a_duty_owner: assert property (eng_pwm_set == 3'h1 && led_owner[0] == 2'h1 |=>
		led_pwm_wr[0] && led_pwm_data[0] == val_q)
		else $error("duty write missed");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
		else $error("stray read data");
	a_ready_done: assert property (cmd_done |-> cmd_ready)
		else $error("busy at done");
endmodule

bind elm_core elm_core_props u_props (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_engine(cmd_engine), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
	.cmd_done(cmd_done), .pc_load(pc_load), .mclk_tick(mclk_tick), .sram_rd(sram_rd),
	.sram_addr(sram_addr), .eng_pwm_set(eng_pwm_set), .eng_pwm_val(eng_pwm_val),
	.led_owner(led_owner), .led_pwm_wr(led_pwm_wr), .led_pwm_data(led_pwm_data),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata));

// *** sim/elm_sram.sv ***
/*
 * Program SRAM model holding mapping rows.
 * Assumes an asynchronous read during the cycle the read strobe is high.
 */
`timescale 1ns/1ps

module elm_sram (
	input  wire logic        sram_rd,
	input  wire logic [6:0]  sram_addr,
	output logic      [15:0] sram_rdata
);
	logic [15:0] mem [0:127];

	// Rows differ per address; upper bits carry junk the block must ignore
	initial begin
		for (int a = 0; a < 128; a++) begin
			mem[a] = {6'h2b, 10'(a * 45 + 1)};
		end
	end

	// Outside a read the data lines show the inverse, never a stale match
	assign sram_rdata = sram_rd ? mem[sram_addr] : ~mem[sram_addr];
endmodule

// *** sim/engine_led_map_and_loop_tb_top.sv ***
/*
 * Self-checking bench for elm_core: table walk, selects, duty, pin, loops.
 * Assumes elm_sram as the program memory.
 */
`timescale 1ns/1ps

module engine_led_map_and_loop_tb_top;
	typedef struct {logic [3:0] op; logic [1:0] e; logic [15:0] arg; logic [23:0] tbl; logic [10:0] m;} elm_row_t;

	logic             core_clk = 1'b0;
	logic             rst = 1'b1;
	logic             cmd_valid = 1'b0, cmd_ready, cmd_done, pc_load, mclk_tick = 1'b0;
	logic [1:0]       cmd_engine = 2'h0;
	logic [3:0]       cmd_op = 4'h0;
	logic [15:0]      cmd_arg = 16'h0000, sram_rdata;
	logic [6:0]       cmd_pc = 7'h00, pc_value, sram_addr, got_pv;
	logic [2:0][7:0]  var_a = '0, var_b = '0, eng_pwm_val = '0;
	logic [7:0]       var_c = 8'h00, adc_value = 8'h00, reg_addr = 8'h00;
	logic [2:0]       eng_pwm_set = 3'h0, eng_gpo_level = 3'h0, tick_div = 3'h0;
	logic [8:0][1:0]  led_owner, eo;
	logic [8:0]       led_pwm_wr;
	logic [8:0][7:0]  led_pwm_data;
	logic             general_output_pin, sram_rd, reg_wr = 1'b0, reg_rd = 1'b0, got_pl;
	logic [31:0]      reg_wdata = 32'h0, rdv, reg_rdata;
	logic [9:0]       m0;
	int               mismatches = 0, num_checks = 0, n;
	elm_row_t         rows [19] = '{
		'{elm_pkg::ELM_OP_TB_BEGIN, 2'h0, 16'h000a, 24'h000a00, 11'h400},
		'{elm_pkg::ELM_OP_TB_FINISH, 2'h0, 16'h000c, 24'h0c0a00, 11'h400},
		'{elm_pkg::ELM_OP_PTR_AT, 2'h0, 16'h808b, 24'h0c0a0b, 11'h400},
		'{elm_pkg::ELM_OP_ACT_NEXT, 2'h0, 16'h0000, 24'h0c0a0c, 11'h00c},
		'{elm_pkg::ELM_OP_ACT_NEXT, 2'h0, 16'h0000, 24'h0c0a0a, 11'h00a},
		'{elm_pkg::ELM_OP_ACT_PREV, 2'h0, 16'h0000, 24'h0c0a0c, 11'h00c},
		'{elm_pkg::ELM_OP_ACT_PREV, 2'h0, 16'h0000, 24'h0c0a0b, 11'h00b},
		'{elm_pkg::ELM_OP_PTR_NEXT, 2'h0, 16'h0000, 24'h0c0a0c, 11'h00b},
		'{elm_pkg::ELM_OP_PTR_NEXT, 2'h0, 16'h0000, 24'h0c0a0a, 11'h00b},
		'{elm_pkg::ELM_OP_PTR_PREV, 2'h0, 16'h0000, 24'h0c0a0c, 11'h00b},
		'{elm_pkg::ELM_OP_ACT_AT, 2'h0, 16'hff5f, 24'h0c0a5f, 11'h05f},
		'{elm_pkg::ELM_OP_PTR_AT, 2'h0, 16'h0000, 24'h0c0a00, 11'h05f},
		'{elm_pkg::ELM_OP_TB_BEGIN_ACT, 2'h0, 16'h0014, 24'h0c1414, 11'h014},
		'{elm_pkg::ELM_OP_SEL, 2'h0, 16'h0010, 24'h0c1414, 11'h600},
		'{elm_pkg::ELM_OP_SEL, 2'h0, 16'h0009, 24'h0c1414, 11'h500},
		'{elm_pkg::ELM_OP_SEL, 2'h0, 16'h0001, 24'h0c1414, 11'h401},
		'{elm_pkg::ELM_OP_SEL, 2'h0, 16'h0003, 24'h0c1414, 11'h404},
		'{elm_pkg::ELM_OP_CLR, 2'h0, 16'h0000, 24'h0c1414, 11'h400},
		'{elm_pkg::ELM_OP_SEL, 2'h1, 16'h0005, 24'h000000, 11'h410}};

	elm_core u_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_engine(cmd_engine), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_pc(cmd_pc), .cmd_done(cmd_done),
		.pc_load(pc_load), .pc_value(pc_value), .mclk_tick(mclk_tick), .var_a(var_a), .var_b(var_b),
		.var_c(var_c), .adc_value(adc_value), .sram_rd(sram_rd), .sram_addr(sram_addr),
		.sram_rdata(sram_rdata), .eng_pwm_set(eng_pwm_set), .eng_pwm_val(eng_pwm_val),
		.eng_gpo_level(eng_gpo_level), .led_owner(led_owner), .led_pwm_wr(led_pwm_wr),
		.led_pwm_data(led_pwm_data), .general_output_pin(general_output_pin), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	elm_sram u_sram (.sram_rd(sram_rd), .sram_addr(sram_addr), .sram_rdata(sram_rdata));

	// ------------------------------------------------------------
	// Clock, shortened master tick (one per eight core cycles)
	// ------------------------------------------------------------
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		tick_div  <= tick_div + 3'h1;
		mclk_tick <= (tick_div == 3'h7);
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic close_out();
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	// Offer one command, wait for done under a bound
	task automatic cmd(input logic [1:0] e, input logic [3:0] op, input logic [15:0] arg, input logic [6:0] pc);
		int i;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_engine <= e;
		cmd_op <= op;
		cmd_arg <= arg;
		cmd_pc <= pc;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		for (i = 0; i < 400; i++) begin
			@(negedge core_clk);
			if (cmd_done === 1'b1) break;
		end
		got_pl = pc_load;
		got_pv = pc_value;
		if (i == 400) begin
			mismatches++;
			$display("CHECK FAILED cmd_done expected 1 seen timeout");
			close_out();
		end
	endtask

	// Repeat one branch until it falls through; n counts the jumps
	task automatic loop_run(input logic [3:0] op, input logic [15:0] arg, input logic [6:0] pc, input int mx);
		n = 0;
		repeat (mx) begin
			cmd(2'h0, op, arg, pc);
			if (got_pl !== 1'b1) break;
			n++;
			chk("pc_value", {25'h0, arg[6:0]}, {25'h0, got_pv});
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int cnts [3] = '{1, 2, 63};
		int vexp [4] = '{1, 2, 3, 2};
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values of every register, plus an unmapped address
		for (int a = 0; a < 8; a++) begin
			rd(8'(a * 4), rdv);
			chk("reset reg", 32'h0, rdv);
		end
		rd(8'hfc, rdv);
		chk("unmapped", 32'h0, rdv);
		// Table rows: command, then pointer/bounds and mask readback
		foreach (rows[i]) begin
			cmd(rows[i].e, rows[i].op, rows[i].arg, 7'h00);
			rd(elm_pkg::REG_TABLE0 + {4'h0, rows[i].e, 2'h0}, rdv);
			chk("table reg", {8'h0, rows[i].tbl}, rdv);
			rd(elm_pkg::REG_MAP0 + {4'h0, rows[i].e, 2'h0}, rdv);
			m0 = rows[i].m[10] ? rows[i].m[9:0] : u_sram.mem[rows[i].m[6:0]][9:0];
			chk("map reg", {22'h0, m0}, rdv);
		end
		// Pin: serial level, then engine level, then serial again after release
		wr(elm_pkg::REG_CTRL, 32'h2);
		rd(elm_pkg::REG_CTRL, rdv);
		chk("ctrl", 32'h2, rdv);
		repeat (4) @(negedge core_clk);
		chk("pin serial", 32'h1, {31'h0, general_output_pin});
		cmd(2'h0, elm_pkg::ELM_OP_SEL, 16'h0010, 7'h00);
		repeat (4) @(negedge core_clk);
		chk("pin engine lo", 32'h0, {31'h0, general_output_pin});
		eng_gpo_level <= 3'h1;
		repeat (4) @(negedge core_clk);
		chk("pin engine hi", 32'h1, {31'h0, general_output_pin});
		eng_gpo_level <= 3'h0;
		cmd(2'h0, elm_pkg::ELM_OP_CLR, 16'h0000, 7'h00);
		repeat (4) @(negedge core_clk);
		chk("pin released", 32'h1, {31'h0, general_output_pin});
		// Duty path through a table row and a single select
		cmd(2'h0, elm_pkg::ELM_OP_ACT_AT, 16'h001e, 7'h00);
		m0 = u_sram.mem[30][9:0];
		@(negedge core_clk);
		for (int i = 0; i < 9; i++) eo[i] = m0[i] ? 2'h1 : (i == 4 ? 2'h2 : 2'h0);
		chk("owner", {14'h0, eo}, {14'h0, led_owner});
		@(posedge core_clk);
		eng_pwm_set <= 3'h1;
		eng_pwm_val[0] <= 8'h77;
		@(posedge core_clk);
		eng_pwm_set <= 3'h0;
		@(negedge core_clk);
		chk("pwm wr e0", {23'h0, m0[8:0] & 9'h1ef}, {23'h0, led_pwm_wr});
		chk("pwm data d1", 32'h77, {24'h0, led_pwm_data[0]});
		cmd(2'h0, elm_pkg::ELM_OP_CLR, 16'h0000, 7'h00);
		@(posedge core_clk);
		eng_pwm_set <= 3'h3;
		eng_pwm_val <= {8'h00, 8'h33, 8'h11};
		@(posedge core_clk);
		eng_pwm_set <= 3'h0;
		@(negedge core_clk);
		chk("pwm wr released", 32'h010, {23'h0, led_pwm_wr});
		chk("pwm data kept", 32'h77, {24'h0, led_pwm_data[0]});
		chk("pwm data d5", 32'h33, {24'h0, led_pwm_data[4]});
		// Numeric loop counts, then the infinite loop
		foreach (cnts[i]) begin
			loop_run(elm_pkg::ELM_OP_BRANCH_NUM, {3'h0, 6'(cnts[i]), 7'h05}, 7'h28, cnts[i] + 2);
			chk("loop jumps", 32'(cnts[i]), 32'(n));
		end
		loop_run(elm_pkg::ELM_OP_BRANCH_NUM, 16'h0009, 7'h32, 70);
		chk("infinite jumps", 32'd70, 32'(n));
		// Variable counts from A, B, C, D and the test converter
		var_a[0] <= 8'h01;
		var_b[0] <= 8'h42;
		var_c <= 8'hc3;
		adc_value <= 8'h01;
		wr(elm_pkg::REG_VAR_D, 32'h2);
		for (int s = 0; s < 5; s++) begin
			if (s == 4) wr(elm_pkg::REG_CTRL, 32'h1);
			loop_run(elm_pkg::ELM_OP_BRANCH_VAR, {7'h0, 2'(s == 4 ? 3 : s), 7'h06}, 7'h3c, 6);
			chk("var jumps", s == 4 ? 32'd1 : 32'(vexp[s]), 32'(n));
		end
		// Inner loop at 41 (one jump) inside outer loop at 42 (two jumps)
		for (int k = 0; k < 9; k++) begin
			cmd(2'h0, elm_pkg::ELM_OP_BRANCH_NUM, (k % 3 == 2) ? 16'h0130 : 16'h00b0, (k % 3 == 2) ? 7'h2a : 7'h29);
			chk("nested load", 32'((9'h06d >> k) & 9'h001), {31'h0, got_pl});
		end
		close_out();
	end
endmodule
